//--- hw/ebra_top.sv
// Refresh timer, reset wait counter, register slave and external access aligner
`timescale 1ns/1ps
module ebra_top
    import ebra_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_b,
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_req_valid,
    input  wire logic        i_req_write,
    input  wire logic [1:0]  i_req_size,
    input  wire logic [1:0]  i_req_space,
    input  wire logic [31:0] i_req_addr,
    input  wire logic [31:0] i_req_wdata,
    output logic             o_req_ready,
    output logic             o_req_done,
    output logic      [31:0] o_req_rdata,
    output logic             o_ext_cyc,
    output logic             o_ext_write,
    output logic      [31:0] o_ext_addr,
    output logic      [31:0] o_ext_wdata,
    output logic      [3:0]  o_write_strobe_n,
    output logic      [3:0]  o_byte_mask,
    input  wire logic        i_ext_ack,
    input  wire logic [31:0] i_ext_rdata,
    output logic             o_refresh_req,
    input  wire logic        i_refresh_done
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic [11:0] div_mask(input logic [2:0] sel);
        logic [11:0] m;
        m = 12'h000;
        unique case (sel)
            3'h1:    m = 12'h003;
            3'h2:    m = 12'h00f;
            3'h3:    m = 12'h03f;
            3'h4:    m = 12'h0ff;
            3'h5:    m = 12'h3ff;
            3'h6:    m = 12'h7ff;
            3'h7:    m = 12'hfff;
            default: m = 12'h000;
        endcase
        return m;
    endfunction : div_mask

    // Lowest byte lane used by one beat
    function automatic logic [1:0] lane_lo(input logic [1:0] pw, input logic [1:0] ulog,
                                           input logic [1:0] a);
        logic [1:0] lo;
        lo = 2'h0;
        if (pw == PW_32)
        begin
            if (ulog == SZ_BYTE)
                lo = 2'h3 - a;                                        // [RULE12] [RULE16]
            else if (ulog == SZ_WORD)
                lo = a[1] ? 2'h0 : 2'h2;                              // [RULE16]
        end
        else if (pw == PW_16 && ulog == SZ_BYTE)
        begin
            lo = a[0] ? 2'h0 : 2'h1;                                  // [RULE17]
        end
        return lo;                                                    // [RULE18]
    endfunction : lane_lo

    function automatic logic [3:0] unit_mask(input logic [1:0] ulog);
        logic [3:0] m;
        m = 4'hf;
        if (ulog == SZ_BYTE)
            m = 4'h1;
        else if (ulog == SZ_WORD)
            m = 4'h3;
        return m;
    endfunction : unit_mask

    function automatic logic [31:0] data_mask(input logic [1:0] ulog);
        logic [31:0] m;
        m = 32'hffffffff;
        if (ulog == SZ_BYTE)
            m = 32'h000000ff;
        else if (ulog == SZ_WORD)
            m = 32'h0000ffff;
        return m;
    endfunction : data_mask

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ebra_state_rec_t q;
    ebra_state_rec_t next_q;

    logic        tick;
    logic        match;
    logic        wait_busy;
    logic        wr_take;
    logic        key_ok;
    logic [1:0]  eff_pw;
    logic [1:0]  lo;
    logic [5:0]  ubits;
    logic [31:0] unit_rd;

    always_comb
    begin
        next_q    = q;
        next_q.done = 1'b0;
        wait_busy = (q.wait_cnt != WAIT_MAX);
        wr_take   = i_avs_write && q.ack && (i_avs_byteenable == 4'hf);
        key_ok    = (i_avs_writedata[31:16] == WR_KEY);               // [RULE5]
        eff_pw    = PW_32;
        lo        = lane_lo(q.pw, q.ulog, q.addr[1:0]);
        ubits     = 6'(6'd8 << q.ulog);
        unit_rd   = (q.rd_s2 >> {lo, 3'b000}) & data_mask(q.ulog);

        // Pin synchronisers
        next_q.ack_s1 = i_ext_ack;
        next_q.ack_s2 = q.ack_s1;
        next_q.rd_s1  = i_ext_rdata;
        next_q.rd_s2  = q.rd_s1;

        // Refresh tick prescaler and counter
        next_q.presc = q.presc + 12'h001;
        tick  = (q.cks != CKS_STOP) && ((q.presc & div_mask(q.cks)) == div_mask(q.cks)); // [RULE19]
        match = tick && (q.tick_cnt == q.cmp);
        if (match)
            next_q.tick_cnt = 8'h00;                                  // [RULE1]
        else if (tick)
            next_q.tick_cnt = q.tick_cnt + 8'h01;                     // [RULE20]

        // Reset wait counter
        if (wait_busy)
            next_q.wait_cnt = q.wait_cnt + 7'h01;                     // [RULE8]

        // Register slave
        next_q.ack = (i_avs_read || i_avs_write) && !q.ack;
        if (i_avs_read && !q.ack)
        begin
            next_q.rdata = 32'h00000000;
            unique case (i_avs_address)
                OFS_CMP:       next_q.rdata[7:0] = q.cmp;             // [RULE7]
                OFS_TICK:      next_q.rdata[7:0] = q.tick_cnt;
                OFS_CTRL_STAT:
                begin
                    next_q.rdata[CMF_BIT]           = q.compare_match_flag;
                    next_q.rdata[CKS_LSB +: 3]      = q.cks;
                end
                OFS_WAIT:      next_q.rdata[6:0] = q.wait_cnt;        // [RULE11]
                OFS_DRAM_CTRL:
                begin
                    next_q.rdata[REFEN_BIT]         = q.refen;
                    next_q.rdata[NWIDTH_LSB +: 2]   = q.nwidth;
                    next_q.rdata[SWIDTH_BIT]        = q.swidth;
                end
                OFS_STATUS:
                begin
                    next_q.rdata[STAT_REQ_BIT]      = q.ref_req;
                    next_q.rdata[STAT_WAIT_BIT]     = wait_busy;
                    next_q.rdata[STAT_BUSY_BIT]     = (q.state != ST_IDLE);
                end
                default:       next_q.rdata = 32'h00000000;
            endcase
        end
        if (wr_take)
        begin
            unique case (i_avs_address)
                OFS_CMP:
                    if (key_ok)
                        next_q.cmp = i_avs_writedata[7:0];            // [RULE5] [RULE7]
                OFS_TICK:
                    if (key_ok)
                        next_q.tick_cnt = i_avs_writedata[7:0];       // [RULE5]
                OFS_CTRL_STAT:
                    if (key_ok)
                    begin
                        next_q.cks = i_avs_writedata[CKS_LSB +: 3];
                        if (!i_avs_writedata[CMF_BIT])
                            next_q.compare_match_flag = 1'b0;
                    end
                OFS_WAIT:
                    if (key_ok)
                        next_q.wait_cnt = i_avs_writedata[6:0];       // [RULE5] [RULE10] [RULE11]
                OFS_DRAM_CTRL:
                begin
                    next_q.refen  = i_avs_writedata[REFEN_BIT];
                    next_q.nwidth = i_avs_writedata[NWIDTH_LSB +: 2];
                    next_q.swidth = i_avs_writedata[SWIDTH_BIT];
                end
                default:
                begin
                end
            endcase
        end

        // Flags set by hardware win over clears
        if (i_refresh_done)
            next_q.ref_req = 1'b0;                                    // [RULE3]
        if (match)
        begin
            next_q.compare_match_flag = 1'b1;                                        // [RULE1]
            if (q.refen)
                next_q.ref_req = 1'b1;                                // [RULE2] [RULE4]
        end

        // Port width of the addressed space
        if (i_req_space == SP_MPX)
            eff_pw = PW_32;                                           // [RULE14]
        else if (i_req_space == SP_SDRAM)
            eff_pw = q.swidth ? PW_32 : PW_16;                        // [RULE14]
        else if (q.nwidth != 2'h3)
            eff_pw = q.nwidth;                                        // [RULE13]

        // Access splitter
        unique case (q.state)
            ST_IDLE:
                if (i_req_valid && !wait_busy)                        // [RULE9]
                begin
                    next_q.write     = i_req_write;
                    next_q.pw        = eff_pw;
                    next_q.ulog      = (i_req_size < eff_pw) ? i_req_size : eff_pw;
                    next_q.beats     = 2'((3'h1 << (i_req_size - next_q.ulog)) - 3'h1); // [RULE15]
                    next_q.addr      = i_req_addr;
                    next_q.req_rdata = 32'h00000000;
                    next_q.dbuf      = i_req_wdata << ((i_req_size == SZ_BYTE) ? 6'h18 :
                                       ((i_req_size == SZ_WORD) ? 6'h10 : 6'h00)); // [RULE12]
                    next_q.state     = ST_BEAT;
                end
            ST_BEAT:
                if (q.ack_s2)
                begin
                    next_q.ext_cyc   = 1'b0;
                    next_q.ext_lanes = 4'h0;
                    next_q.req_rdata = (q.req_rdata << ubits) | unit_rd; // [RULE17] [RULE18]
                    next_q.dbuf      = q.dbuf << ubits;
                    next_q.addr      = q.addr + 32'(unit_mask(q.ulog) == 4'h1 ? 1 :
                                                    (unit_mask(q.ulog) == 4'h3 ? 2 : 4));
                    next_q.fin       = (q.beats == 2'h0);
                    next_q.beats     = q.beats - 2'h1;
                    next_q.done      = (q.beats == 2'h0);
                    next_q.state     = ST_GAP;
                end
            ST_GAP:
                if (!q.ack_s2 && !(wait_busy && !q.fin))              // [RULE9] [RULE10]
                    next_q.state = q.fin ? ST_IDLE : ST_BEAT;
            default:
                next_q.state = ST_IDLE;
        endcase

        // Present a new beat on the external bus
        if (next_q.state == ST_BEAT && q.state != ST_BEAT)
        begin
            next_q.ext_cyc   = 1'b1;
            next_q.ext_addr  = next_q.addr;
            next_q.ext_lanes = unit_mask(next_q.ulog)
                               << lane_lo(next_q.pw, next_q.ulog, next_q.addr[1:0]); // [RULE16]
            if (next_q.ulog == SZ_BYTE)
                next_q.ext_wdata = {4{next_q.dbuf[31:24]}};           // [RULE12]
            else if (next_q.ulog == SZ_WORD)
                next_q.ext_wdata = {2{next_q.dbuf[31:16]}};
            else
                next_q.ext_wdata = next_q.dbuf;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
            q <= '0;                                                  // [RULE6]
        else
            q <= next_q;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_avs_readdata    = q.rdata;
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !q.ack;
    assign o_req_ready       = (q.state == ST_IDLE) && !wait_busy;    // [RULE9]
    assign o_req_done        = q.done;
    assign o_req_rdata       = q.req_rdata;
    assign o_ext_cyc         = q.ext_cyc;
    assign o_ext_write       = q.write;
    assign o_ext_addr        = q.ext_addr;
    assign o_ext_wdata       = q.ext_wdata;
    assign o_write_strobe_n  = (q.ext_cyc && q.write) ? ~q.ext_lanes : 4'hf; // [RULE21]
    assign o_byte_mask       = ~q.ext_lanes;                          // [RULE21]
    assign o_refresh_req     = q.ref_req;

endmodule : ebra_top

//--- hw/ebra_pkg.sv
// Constants, types and register map of the external bus refresh/align block
//
// Summary of operation
// RULE1: Compare value equal to tick counter sets match flag and clears counter.
// RULE2: With refresh enable set, every compare match raises a refresh request.
// RULE3: Refresh request stays pending until refresh is reported done.
// RULE4: A match while a request is pending does not queue a second request.
// RULE5: Timer register writes take effect only with key in bits 31 to 16.
// RULE6: Compare register clears on power-on reset only.
// RULE7: Compare register reads zero above bit 7; bits 7 to 0 read/write.
// RULE8: Reset wait counter counts up after reset and halts at maximum.
// RULE9: No external access starts while the wait counter is counting.
// RULE10: Writing the wait counter reloads it and suspends accesses again.
// RULE11: Wait counter reads zero above bit 6; bits 6 to 0 read/write.
// RULE12: External bus is big endian; byte offset 0 is most significant.
// RULE13: Normal memory supports 8, 16 and 32 bit port widths.
// RULE14: SDRAM is 16 or 32 bits wide; multiplexed I/O is 32 bits.
// RULE15: Accesses wider than the port are split into sequential narrower ones.
// RULE16: 32-bit port lane and strobe mapping for byte, word and longword.
// RULE17: 16-bit port lane mapping; longword is two words, upper half first.
// RULE18: 8-bit port uses lane 0 only; bytes in ascending address order.
// RULE19: Clock select picks tick source: stop or divide by 4 to 4096.
// RULE20: Tick counter wraps from 255 to zero without a match.
// RULE21: Lanes without an addressed byte keep strobe and mask negated.
package ebra_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [4:0]  OFS_CMP       = 5'h00;
    localparam logic [4:0]  OFS_TICK      = 5'h04;
    localparam logic [4:0]  OFS_CTRL_STAT = 5'h08;
    localparam logic [4:0]  OFS_WAIT      = 5'h0c;
    localparam logic [4:0]  OFS_DRAM_CTRL = 5'h10;
    localparam logic [4:0]  OFS_STATUS    = 5'h14;

    // ------------------------------------------------------------------
    // Fields, keys and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] WR_KEY        = 16'ha55a;
    localparam int          CMF_BIT       = 7;
    localparam int          CKS_LSB       = 3;
    localparam int          REFEN_BIT     = 0;
    localparam int          NWIDTH_LSB    = 1;
    localparam int          SWIDTH_BIT    = 3;
    localparam int          STAT_REQ_BIT  = 0;
    localparam int          STAT_WAIT_BIT = 1;
    localparam int          STAT_BUSY_BIT = 2;
    localparam logic [7:0]  CMP_RESET     = 8'h00;
    localparam logic [6:0]  WAIT_RESET    = 7'h00;
    localparam logic [6:0]  WAIT_MAX      = 7'h7f;
    localparam logic [2:0]  CKS_STOP      = 3'h0;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [1:0]  PW_8          = 2'h0;
    localparam logic [1:0]  PW_16         = 2'h1;
    localparam logic [1:0]  PW_32         = 2'h2;
    localparam logic [1:0]  SZ_BYTE       = 2'h0;
    localparam logic [1:0]  SZ_WORD       = 2'h1;
    localparam logic [1:0]  SZ_LONG       = 2'h2;
    localparam logic [1:0]  SP_NORMAL     = 2'h0;
    localparam logic [1:0]  SP_SDRAM      = 2'h1;
    localparam logic [1:0]  SP_MPX        = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_BEAT, ST_GAP} ebra_state_t;

    typedef struct packed {
        logic              ack;
        logic [31:0]       rdata;
        logic [7:0]        cmp;
        logic [7:0]        tick_cnt;
        logic [11:0]       presc;
        logic              compare_match_flag;
        logic [2:0]        cks;
        logic              refen;
        logic [1:0]        nwidth;
        logic              swidth;
        logic [6:0]        wait_cnt;
        logic              ref_req;
        ebra_state_t       state;
        logic              write;
        logic [1:0]        pw;
        logic [1:0]        ulog;
        logic [1:0]        beats;
        logic              fin;
        logic [31:0]       addr;
        logic [31:0]       dbuf;
        logic              done;
        logic [31:0]       req_rdata;
        logic              ext_cyc;
        logic [31:0]       ext_addr;
        logic [31:0]       ext_wdata;
        logic [3:0]        ext_lanes;
        logic              ack_s1;
        logic              ack_s2;
        logic [31:0]       rd_s1;
        logic [31:0]       rd_s2;
    } ebra_state_rec_t;

endpackage : ebra_pkg

//--- test/ebra_chk.sv
// Port checker of the refresh and alignment block
`timescale 1ns/1ps
module ebra_chk
(
    input wire logic        i_ref_clk,
    input wire logic        i_rst_b,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic        o_avs_waitrequest,
    input wire logic        o_req_ready,
    input wire logic        o_ext_cyc,
    input wire logic        o_ext_write,
    input wire logic [31:0] o_ext_addr,
    input wire logic [3:0]  o_write_strobe_n,
    input wire logic [3:0]  o_byte_mask,
    input wire logic        i_ext_ack,
    input wire logic        o_refresh_req,
    input wire logic        i_refresh_done
);
    // --------------------
    // Edges since reset
    // --------------------
    logic [7:0] since_rst;
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
            since_rst <= 8'h00;
        else if (since_rst != 8'hff)
            since_rst <= since_rst + 8'h01;
    end
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);
    // --------------------
    // Properties
    // --------------------
    property p_ready_wait;
        o_req_ready |-> since_rst >= 8'h7f;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready too early");
    property p_cyc_wait;
        $rose(o_ext_cyc) |-> since_rst >= 8'h80;
    endproperty
    a_cyc_wait: assert property (p_cyc_wait) else $error("beat too early");
    property p_req_hold;
        o_refresh_req && !i_refresh_done |=> o_refresh_req;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request lost");
    property p_req_drop;
        $fell(o_refresh_req) |-> $past(i_refresh_done);
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("request dropped");
    property p_bus_answer;
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("slow answer");
    property p_strobe_write;
        o_write_strobe_n != 4'hf |-> o_ext_cyc && o_ext_write && o_write_strobe_n == o_byte_mask;
    endproperty
    a_strobe_write: assert property (p_strobe_write) else $error("stray strobe");
    property p_idle_mask;
        !o_ext_cyc |-> o_byte_mask == 4'hf && o_write_strobe_n == 4'hf;
    endproperty
    a_idle_mask: assert property (p_idle_mask) else $error("idle lane active");
    property p_beat_hold;
        o_ext_cyc && !i_ext_ack |=> o_ext_cyc && $stable(o_ext_addr);
    endproperty
    a_beat_hold: assert property (p_beat_hold) else $error("beat released");
endmodule : ebra_chk
bind ebra_top ebra_chk ebra_chk_inst (.i_ref_clk, .i_rst_b, .i_avs_read, .i_avs_write,
    .o_avs_waitrequest, .o_req_ready, .o_ext_cyc, .o_ext_write, .o_ext_addr,
    .o_write_strobe_n, .o_byte_mask, .i_ext_ack, .o_refresh_req, .i_refresh_done);

//--- test/ebra_mem.sv
// Behavioural external memory answering aligned beats
`timescale 1ns/1ps
module ebra_mem
    import ebra_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_cyc,
    input  wire logic        i_write,
    input  wire logic [31:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_mask,
    input  wire logic [1:0]  i_width,
    input  wire logic [3:0]  i_delay,
    output logic             o_ack,
    output logic      [31:0] o_rdata
);
    // --------------------
    // Storage and handshake
    // --------------------
    logic [7:0] mem [0:255];
    logic [3:0] cnt;
    logic [7:0] base;
    int         nb;
    initial
    begin
        o_ack = 1'b0;
        o_rdata = 32'h5a5a5a5a;
        cnt = 4'h0;
        foreach (mem[i]) mem[i] = 8'h00;
    end
    always @(posedge i_ref_clk)
    begin
        nb = (i_width == PW_8) ? 1 : (i_width == PW_16) ? 2 : 4;
        base = i_addr[7:0] & ~8'(nb - 1);
        if (i_cyc && !o_ack)
        begin
            // Top lane of the port holds the lowest address
            if (cnt == 4'h0)
                for (int k = 0; k < 4; k++)
                    o_rdata[8*k+:8] <= (k < nb) ? mem[base + 8'(nb - 1 - k)] : ~o_rdata[8*k+:8];
            if (cnt == i_delay)
            begin
                for (int k = 0; k < nb; k++)
                    if (i_write && !i_mask[k])
                        mem[base + 8'(nb - 1 - k)] <= i_wdata[8*k+:8];
                o_ack <= 1'b1;
                cnt <= 4'h0;
            end
            else
                cnt <= cnt + 4'h1;
        end
        else if (!i_cyc && o_ack)
        begin
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
        end
    end
endmodule : ebra_mem

//--- test/tb_ebra_top.sv
// Self-checking bench of the refresh and alignment block
`timescale 1ns/1ps
module tb_ebra_top
    import ebra_pkg::*;
;
    logic        i_ref_clk, i_rst_b, i_avs_read, i_avs_write, i_req_valid, i_req_write;
    logic        i_refresh_done;
    logic [4:0]  i_avs_address;
    logic [3:0]  i_avs_byteenable, dly;
    logic [1:0]  i_req_size, i_req_space, pw;
    logic [31:0] i_avs_writedata, i_req_addr, i_req_wdata, q, t;
    wire  [31:0] o_avs_readdata, o_req_rdata, o_ext_addr, o_ext_wdata, i_ext_rdata;
    wire  [3:0]  o_write_strobe_n, o_byte_mask;
    wire         o_avs_waitrequest, o_req_ready, o_req_done, o_ext_cyc, o_ext_write;
    wire         i_ext_ack, o_refresh_req;
    int          miscompares, checks, b, n;
    ebra_top ebra_top_inst (.i_ref_clk, .i_rst_b, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_req_valid,
        .i_req_write, .i_req_size, .i_req_space, .i_req_addr, .i_req_wdata, .o_req_ready,
        .o_req_done, .o_req_rdata, .o_ext_cyc, .o_ext_write, .o_ext_addr, .o_ext_wdata,
        .o_write_strobe_n, .o_byte_mask, .i_ext_ack, .i_ext_rdata, .o_refresh_req,
        .i_refresh_done);
    ebra_mem ebra_mem_inst (.i_ref_clk, .i_cyc(o_ext_cyc), .i_write(o_ext_write),
        .i_addr(o_ext_addr), .i_wdata(o_ext_wdata), .i_mask(o_byte_mask), .i_width(pw),
        .i_delay(dly), .o_ack(i_ext_ack), .o_rdata(i_ext_rdata));
    // --------------------
    // Shared tasks
    // --------------------
    task automatic report_and_stop();
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic tmo();
        miscompares++;
        report_and_stop();
    endtask : tmo
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wait_ready();
        for (n = 1; n < 300; n++)
        begin
            @(posedge i_ref_clk);
            if (o_req_ready === 1'b1)
                break;
        end
        if (n == 300)
            tmo();
    endtask : wait_ready
    task automatic avs(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        @(posedge i_ref_clk);
        i_avs_read <= !w;
        i_avs_write <= w;
        i_avs_address <= a;
        i_avs_writedata <= d;
        for (k = 0; k < 20; k++)
        begin
            @(posedge i_ref_clk);
            if (o_avs_waitrequest === 1'b0)
                break;
        end
        if (k == 20)
            tmo();
        q = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask : avs
    task automatic req(input logic w, input logic [1:0] sz, input logic [1:0] sp,
                       input logic [31:0] a, input logic [31:0] d);
        logic pc;
        pc = 1'b0;
        b = 0;
        @(posedge i_ref_clk);
        i_req_valid <= 1'b1;
        i_req_write <= w;
        i_req_size <= sz;
        i_req_space <= sp;
        i_req_addr <= a;
        i_req_wdata <= d;
        wait_ready();
        i_req_valid <= 1'b0;
        for (n = 0; n < 400; n++)
        begin
            @(posedge i_ref_clk);
            if (o_ext_cyc === 1'b1 && pc === 1'b0)
                b++;
            pc = o_ext_cyc;
            if (o_req_done === 1'b1)
                break;
        end
        if (n == 400)
            tmo();
        q = o_req_rdata;
    endtask : req
    // --------------------
    // Scenarios
    // --------------------
    task automatic t_reset_keys();
        wait_ready();
        chk("wait length", 32'd128, n);
        avs(0, OFS_CMP, 0);
        chk("cmp reset", 32'h0, q);
        avs(1, OFS_CMP, 32'h1234_00c3);
        avs(0, OFS_CMP, 0);
        chk("cmp no key", 32'h0, q);
        avs(1, OFS_CMP, 32'ha55a_ffc3);
        avs(0, OFS_CMP, 0);
        chk("cmp keyed", 32'hc3, q);
        avs(1, OFS_WAIT, 32'ha55a_ff70);
        avs(0, OFS_WAIT, 0);
        chk("wait reload", 32'h70, {q[31:4], 4'h0});
        chk("ready held", 32'h0, 32'(o_req_ready));
        avs(0, OFS_STATUS, 0);
        chk("status wait", 32'h2, q);
        wait_ready();
        avs(0, OFS_WAIT, 0);
        chk("wait max", 32'h7f, q);
    endtask : t_reset_keys
    task automatic t_refresh();
        avs(1, OFS_DRAM_CTRL, 32'h0);
        avs(1, OFS_CMP, 32'ha55a_0003);
        avs(1, OFS_CTRL_STAT, 32'ha55a_0008);
        repeat (100) @(posedge i_ref_clk);
        chk("req disabled", 32'h0, 32'(o_refresh_req));
        avs(0, OFS_CTRL_STAT, 0);
        chk("match flag", 32'h1, 32'(q[CMF_BIT]));
        avs(0, OFS_TICK, 0);
        chk("tick bound", 32'h1, 32'(q < 32'h4));
        avs(1, OFS_DRAM_CTRL, 32'h1);
        repeat (100) @(posedge i_ref_clk);
        chk("req raised", 32'h1, 32'(o_refresh_req));
        avs(1, OFS_CTRL_STAT, 32'ha55a_0000);
        avs(0, OFS_TICK, 0);
        t = q;
        repeat (40) @(posedge i_ref_clk);
        avs(0, OFS_TICK, 0);
        chk("tick stopped", t, q);
        chk("req pending", 32'h1, 32'(o_refresh_req));
        i_refresh_done <= 1'b1;
        @(posedge i_ref_clk);
        i_refresh_done <= 1'b0;
        repeat (10) @(posedge i_ref_clk);
        chk("req single", 32'h0, 32'(o_refresh_req));
    endtask : t_refresh
    task automatic t_align();
        logic [31:0] a;
        for (int i = 0; i < 3; i++)
        begin
            a = 32'h20 + 32'(4 * i);
            pw <= 2'(i);
            dly <= (i == 1) ? 4'h5 : 4'h1;
            avs(1, OFS_DRAM_CTRL, 32'(2 * i));
            req(1, SZ_LONG, SP_NORMAL, a, 32'h11223344);
            chk("long beats", 32'h4 >> i, b);
            req(1, SZ_BYTE, SP_NORMAL, a + 1, 32'haa);
            req(1, SZ_WORD, SP_NORMAL, a + 2, 32'hbbcc);
            chk("word beats", (i == 0) ? 2 : 1, b);
            req(0, SZ_LONG, SP_NORMAL, a, 0);
            chk("long read", 32'h11aabbcc, q);
            req(0, SZ_WORD, SP_NORMAL, a, 0);
            chk("word read", 32'h11aa, q);
            req(0, SZ_BYTE, SP_NORMAL, a + 3, 0);
            chk("byte read", 32'hcc, q);
        end
        avs(1, OFS_DRAM_CTRL, 32'h0);
        pw <= PW_16;
        req(0, SZ_LONG, SP_SDRAM, 32'h20, 0);
        chk("sdram beats", 32'h2, b);
        chk("sdram read", 32'h11aabbcc, q);
        pw <= PW_32;
        req(0, SZ_LONG, SP_MPX, 32'h24, 0);
        chk("mpx beats", 32'h1, b);
        chk("mpx read", 32'h11aabbcc, q);
    endtask : t_align
    initial
    begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    initial
    begin
        {i_rst_b, i_avs_read, i_avs_write, i_req_valid, i_req_write, i_refresh_done} = 6'h00;
        {i_avs_address, i_avs_writedata, i_req_addr, i_req_wdata} = 101'h0;
        {i_req_size, i_req_space, pw, dly} = 10'h001;
        i_avs_byteenable = 4'hf;
        repeat (6) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        t_reset_keys();
        t_refresh();
        t_align();
        report_and_stop();
    end
endmodule : tb_ebra_top
